// [imu_multiply_unit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "imu_defs.svh"

module imu_multiply_unit #(
  parameter int MAX_STEPS = `IMU_MAX_STEPS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire imu_pkg::imu_req_s req_in,
  output logic busy_out,
  output logic done_out,
  output imu_pkg::imu_rsp_s rsp_out
);

  // Refuse array depths that the four-step sequencer cannot serve.
  if (MAX_STEPS != 4) begin : g_bad_steps
    $error("imu_multiply_unit serves exactly four array cycles of eight bits");
  end

  typedef enum logic [1:0] {
    IMU_IDLE,
    IMU_SEQ,
    IMU_ARRAY,
    IMU_FINISH
  } imu_state_e;

  imu_state_e state;
  imu_state_e next_state;
  imu_pkg::imu_op_e op;
  imu_pkg::imu_op_e next_op;
  logic set_flags;
  logic next_set_flags;
  logic [63:0] acc;
  logic [63:0] next_acc;
  logic [63:0] mcand;
  logic [63:0] next_mcand;
  logic [32:0] mplier;
  logic [32:0] next_mplier;
  logic [2:0] steps_left;
  logic [2:0] next_steps_left;
  logic [1:0] extra_left;
  logic [1:0] next_extra_left;
  logic done;
  logic next_done;
  imu_pkg::imu_rsp_s rsp;
  imu_pkg::imu_rsp_s next_rsp;

  logic is_long;
  logic is_signed;
  logic is_acc;
  logic [2:0] req_steps;
  logic [63:0] step_sum;
  logic [63:0] booth_pp;

  // Decode of the incoming operation.
  always_comb begin
    is_long = (req_in.op != imu_pkg::IMU_SHORT_MULTIPLY) && (req_in.op != imu_pkg::IMU_SHORT_MULTIPLY_ACCUMULATE);
    is_signed = (req_in.op == imu_pkg::IMU_SIGNED_LONG_MULTIPLY) ||
      (req_in.op == imu_pkg::IMU_SIGNED_LONG_MULTIPLY_ACCUMULATE);
    is_acc = (req_in.op == imu_pkg::IMU_SHORT_MULTIPLY_ACCUMULATE) ||
      (req_in.op == imu_pkg::IMU_UNSIGNED_LONG_MULTIPLY_ACCUMULATE) ||
      (req_in.op == imu_pkg::IMU_SIGNED_LONG_MULTIPLY_ACCUMULATE);
  end

  // Array cycle count from the multiplier operand.
  imu_step_count u_step_count (
    .multiplier_in(req_in.multiplier),
    .long_unsigned_in(is_long & ~is_signed),
    .steps_out(req_steps)
  );

  // Radix-4 Booth recoding of eight multiplier bits into four partial products.
  always_comb begin
    logic [2:0] grp;
    logic [63:0] term;
    grp = 3'b000;
    term = 64'h0000_0000_0000_0000;
    booth_pp = 64'h0000_0000_0000_0000;
    for (int g = 0; g < 4; g++) begin
      grp = mplier[2 * g +: 3];
      term = mcand << (2 * g);
      unique case (grp)
        3'b001, 3'b010: booth_pp = booth_pp + term;
        3'b011: booth_pp = booth_pp + (term << 1);
        3'b100: booth_pp = booth_pp - (term << 1);
        3'b101, 3'b110: booth_pp = booth_pp - term;
        default: booth_pp = booth_pp;
      endcase
    end
    // Early stop reads the top retired bit as a sign; when the bits above disagree with it,
    // the dropped digit is restored here so zero-filled and one-filled multipliers come out right.
    if (steps_left == 3'd1 && mplier[8] != mplier[9]) begin
      if (mplier[8]) begin
        booth_pp = booth_pp + (mcand << `IMU_STEP_W);
      end else begin
        booth_pp = booth_pp - (mcand << `IMU_STEP_W);
      end
    end
    step_sum = acc + booth_pp;
  end

  // Sequencer: one sequential cycle, m array cycles, then the extra internal cycles.
  always_comb begin
    logic [63:0] prod;
    prod = 64'h0000_0000_0000_0000;
    next_state = state;
    next_op = op;
    next_set_flags = set_flags;
    next_acc = acc;
    next_mcand = mcand;
    next_mplier = mplier;
    next_steps_left = steps_left;
    next_extra_left = extra_left;
    next_done = 1'b0;
    next_rsp = rsp;
    unique case (state)
      IMU_IDLE: begin
        if (start_in && req_in.cond_pass) begin
          next_state = IMU_SEQ;
          next_op = req_in.op;
          next_set_flags = req_in.set_flags;
          next_mcand = is_signed ? {{32{req_in.first_operand[31]}}, req_in.first_operand} :
            {32'h0000_0000, req_in.first_operand};
          next_mplier = {req_in.multiplier, 1'b0};
          if (!is_acc) begin
            next_acc = 64'h0000_0000_0000_0000;
          end else if (is_long) begin
            next_acc = {req_in.acc_high, req_in.acc_low};
          end else begin
            next_acc = {32'h0000_0000, req_in.accumulate};
          end
          next_steps_left = req_steps;
          next_extra_left = 2'((is_acc ? `IMU_ACC_EXTRA : 0) + (is_long ? `IMU_LONG_EXTRA : 0));
        end
      end
      IMU_SEQ: begin
        next_state = IMU_ARRAY;
      end
      IMU_ARRAY: begin
        next_acc = step_sum;
        next_mcand = mcand << `IMU_STEP_W;
        next_mplier = {8'h00, mplier[32:8]};
        if (op == imu_pkg::IMU_SIGNED_LONG_MULTIPLY || op == imu_pkg::IMU_SIGNED_LONG_MULTIPLY_ACCUMULATE) begin
          next_mplier[32:25] = {8{mplier[32]}};
        end
        next_steps_left = steps_left - 3'd1;
        if (steps_left == 3'd1) begin
          next_state = (extra_left == 2'd0) ? IMU_IDLE : IMU_FINISH;
          next_done = (extra_left == 2'd0);
        end
      end
      IMU_FINISH: begin
        next_extra_left = extra_left - 2'd1;
        if (extra_left == 2'd1) begin
          next_state = IMU_IDLE;
          next_done = 1'b1;
        end
      end
      default: begin
        next_state = IMU_IDLE;
      end
    endcase
    if (next_done) begin
      prod = (state == IMU_ARRAY) ? step_sum : acc;
      next_rsp.low = prod[31:0];
      next_rsp.high = prod[63:32];
      next_rsp.write_low = 1'b1;
      next_rsp.write_high = (op != imu_pkg::IMU_SHORT_MULTIPLY) && (op != imu_pkg::IMU_SHORT_MULTIPLY_ACCUMULATE);
      next_rsp.write_flags = set_flags;
      if (next_rsp.write_high) begin
        next_rsp.flags = {prod[63], ~|prod, 2'b00};
        next_rsp.flag_mask = 4'hf;
      end else begin
        next_rsp.flags = {prod[31], ~|prod[31:0], 2'b00};
        next_rsp.flag_mask = 4'he;
      end
    end else begin
      next_rsp.write_low = 1'b0;
      next_rsp.write_high = 1'b0;
      next_rsp.write_flags = 1'b0;
    end
  end

  // State registers.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= IMU_IDLE;
      op <= imu_pkg::IMU_SHORT_MULTIPLY;
      set_flags <= 1'b0;
      acc <= 64'h0000_0000_0000_0000;
      mcand <= 64'h0000_0000_0000_0000;
      mplier <= 33'h0_0000_0000;
      steps_left <= 3'd0;
      extra_left <= 2'd0;
      done <= 1'b0;
      rsp <= '0;
    end else begin
      state <= next_state;
      op <= next_op;
      set_flags <= next_set_flags;
      acc <= next_acc;
      mcand <= next_mcand;
      mplier <= next_mplier;
      steps_left <= next_steps_left;
      extra_left <= next_extra_left;
      done <= next_done;
      rsp <= next_rsp;
    end
  end

  // Busy stalls dependent issue until the results are written.
  assign busy_out = (state != IMU_IDLE);
  assign done_out = done;
  assign rsp_out = rsp;

  logic [3:0] cyc;
  logic [3:0] exp_cyc;
  // Cycle counter and expected length for the timing checks.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cyc <= 4'd0;
      exp_cyc <= 4'd0;
    end else if (start_in && req_in.cond_pass && state == IMU_IDLE) begin
      cyc <= 4'd0; // The taking edge counts as edge zero.
      exp_cyc <= 4'(1 + req_steps + (is_acc ? 1 : 0) + (is_long ? 1 : 0));
    end else if (state != IMU_IDLE) begin
      cyc <= cyc + 4'd1;
    end
  end

  AST_NO_START_WHEN_FAIL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state == IMU_IDLE && start_in && !req_in.cond_pass) |=> state == IMU_IDLE)
    else $error("Failed condition started a multiply.");
  AST_DONE_TIMING: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    done |-> cyc == exp_cyc)
    else $error("Multiply length does not match cycle count.");
  AST_FLAGS_ONLY_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rsp.write_flags |-> done && set_flags)
    else $error("Flags written without set-flags bit.");
  AST_SHORT_N: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (done && !rsp.write_high) |-> rsp.flags[`IMU_FLAG_N] == rsp.low[31] && !rsp.flag_mask[`IMU_FLAG_V])
    else $error("Short negative flag wrong or overflow touched.");
  AST_LONG_Z: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (done && rsp.write_high) |-> rsp.flags[`IMU_FLAG_Z] == ({rsp.high, rsp.low} == 64'h0000_0000_0000_0000))
    else $error("Long zero flag wrong.");
  AST_LONG_N: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (done && rsp.write_high) |-> rsp.flags[`IMU_FLAG_N] == rsp.high[31])
    else $error("Long negative flag wrong.");
  AST_BUSY_UNTIL_DONE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(busy_out) |-> done)
    else $error("Busy dropped without done.");
  AST_STEPS_BOUND: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == IMU_SEQ |-> steps_left >= 3'd1 && steps_left <= 3'd4)
    else $error("Array cycle count out of range.");
  AST_FINISH_BOUND: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    state == IMU_SEQ |-> ##[1:7] done)
    else $error("Multiply did not finish in time.");
  AST_DONE_PULSE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    done |=> !done && !rsp.write_low)
    else $error("Done or write strobe held longer than one cycle.");

  COV_SHORT: cover property (@(posedge clk_in) done && !rsp.write_high);
  COV_LONG: cover property (@(posedge clk_in) done && rsp.write_high);
  COV_FLAGS: cover property (@(posedge clk_in) rsp.write_flags);
  // A failed condition and a request refused while busy.
  COV_COND_FAIL: cover property (@(posedge clk_in) state == IMU_IDLE && start_in && !req_in.cond_pass);
  COV_REFUSED: cover property (@(posedge clk_in) start_in && busy_out);

endmodule // imu_multiply_unit
`default_nettype wire

// [imu_defs.svh]
`ifndef IMU_DEFS_SVH
`define IMU_DEFS_SVH

// Operand width and array step width.
`define IMU_WORD_W 32
`define IMU_STEP_W 8
// Sequential cycles charged to every multiply.
`define IMU_SEQ_CYCLES 1
// Extra internal cycles for the accumulating and long forms.
`define IMU_ACC_EXTRA 1
`define IMU_LONG_EXTRA 1
// Largest number of array cycles.
`define IMU_MAX_STEPS 4
// Flag positions inside the flag nibble.
`define IMU_FLAG_N 3
`define IMU_FLAG_Z 2
`define IMU_FLAG_C 1
`define IMU_FLAG_V 0
// Reset value of the result outputs.
`define IMU_RESULT_RST 32'h0000_0000

`endif

// [imu_pkg.sv]
package imu_pkg;

  // Multiply operation selected by decode.
  typedef enum logic [2:0] {
    IMU_SHORT_MULTIPLY,
    IMU_SHORT_MULTIPLY_ACCUMULATE,
    IMU_UNSIGNED_LONG_MULTIPLY,
    IMU_UNSIGNED_LONG_MULTIPLY_ACCUMULATE,
    IMU_SIGNED_LONG_MULTIPLY,
    IMU_SIGNED_LONG_MULTIPLY_ACCUMULATE
  } imu_op_e;

  // Request from decode and register file.
  typedef struct packed {
    imu_op_e op;
    logic cond_pass;
    logic set_flags;
    logic [31:0] first_operand;
    logic [31:0] multiplier;
    logic [31:0] accumulate;
    logic [31:0] acc_high;
    logic [31:0] acc_low;
  } imu_req_s;

  // Result handed back for write-back.
  typedef struct packed {
    logic write_low;
    logic write_high;
    logic write_flags;
    logic [31:0] low;
    logic [31:0] high;
    logic [3:0] flags;
    logic [3:0] flag_mask;
  } imu_rsp_s;

endpackage

// [imu_step_count.sv]
`timescale 1ns/1ps
`default_nettype none
`include "imu_defs.svh"

module imu_step_count (
  input wire logic [31:0] multiplier_in,
  input wire logic long_unsigned_in,
  output logic [2:0] steps_out
);

  logic [2:0] tier_ok;

  // Tier k is taken when bits from 8*(k+1) up to the top are all zero, or all one unless long_unsigned_in is set.
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_tier
      localparam int LO = `IMU_STEP_W * (k + 1);
      logic all_zero;
      logic all_one;
      assign all_zero = ~|multiplier_in[31:LO];
      assign all_one = &multiplier_in[31:LO];
      assign tier_ok[k] = all_zero | (all_one & ~long_unsigned_in);
    end
  endgenerate

  // Ordered tier tests; the first match sets the array cycle count.
  always_comb begin
    if (tier_ok[0]) begin
      steps_out = 3'd1;
    end else if (tier_ok[1]) begin
      steps_out = 3'd2;
    end else if (tier_ok[2]) begin
      steps_out = 3'd3;
    end else begin
      steps_out = 3'd4;
    end
  end

endmodule // imu_step_count
`default_nettype wire

// [imu_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module imu_core_model (
  input wire logic clk_in,
  input wire logic busy_in,
  input wire logic done_in,
  input wire imu_pkg::imu_rsp_s rsp_in,
  output logic start_out,
  output imu_pkg::imu_req_s req_out
);
  // Request lines start quiet.
  initial begin
    start_out = 1'b0;
    req_out = '0;
  end

  // Issues one request, holds it across the taking edge, then counts edges until the answer.
  task automatic issue(input imu_pkg::imu_req_s r, input bit pest, output int lat, output imu_pkg::imu_rsp_s cap);
    int n;
    imu_pkg::imu_req_s idle_req;
    while (busy_in === 1'b1) @(negedge clk_in);
    @(negedge clk_in);
    req_out = r;
    start_out = 1'b1;
    // Released lines show the inverse except op and cond_pass; when pestering, a live request is kept up while busy.
    idle_req = ~r;
    idle_req.op = r.op;
    idle_req.cond_pass = 1'b1;
    @(negedge clk_in);
    start_out = pest;
    req_out = idle_req;
    lat = 0;
    for (n = 0; n < 12 && done_in !== 1'b1; n++) begin
      @(negedge clk_in);
      lat++;
    end
    start_out = 1'b0;
    cap = rsp_in;
  endtask
endmodule // imu_core_model
`default_nettype wire

// [imu_multiply_unit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module imu_multiply_unit_tb;
  logic clk_in;
  logic rst_n_in;
  logic start;
  logic busy;
  logic done;
  imu_pkg::imu_req_s req;
  imu_pkg::imu_rsp_s rsp;
  imu_pkg::imu_rsp_s last;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] mult_tab [5] = '{32'hFFFF_FFF6, 32'h0000_0014, 32'h0000_1234, 32'h00AB_0000, 32'h1234_5678};

  imu_multiply_unit #(.MAX_STEPS(4)) u_imu_multiply_unit (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .start_in(start), .req_in(req), .busy_out(busy), .done_out(done), .rsp_out(rsp));
  imu_core_model u_imu_core_model (.clk_in(clk_in), .busy_in(busy), .done_in(done), .rsp_in(rsp),
    .start_out(start), .req_out(req));

  // The clock toggles every half period of 10 ns.
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // A hung run is cut short after a fixed number of cycles.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Counts one comparison and reports a failed one.
  task automatic chk(input bit c, input string s);
    tests_run++;
    if (!c) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, s);
    end
  endtask

  // Runs one multiply and judges result, strobes, flags and cycle count.
  task automatic do_op(input int k, input logic sf, input logic [31:0] a, input logic [31:0] b, input bit pest);
    imu_pkg::imu_req_s r;
    imu_pkg::imu_rsp_s c;
    int lat;
    int m;
    bit lng;
    bit uns;
    bit ac;
    logic [63:0] e;
    lng = k >= 2;
    uns = k == 2 || k == 3;
    ac = k % 2 == 1;
    r = '{op: imu_pkg::imu_op_e'(k), cond_pass: 1'b1, set_flags: sf, first_operand: a, multiplier: b,
      accumulate: 32'h1357_9BDF, acc_high: 32'h0246_8ACE, acc_low: 32'hFEDC_BA98};
    if (uns) e = {32'h0000_0000, a} * {32'h0000_0000, b};
    else e = {{32{a[31]}}, a} * {{32{b[31]}}, b};
    if (lng && ac) e = e + {r.acc_high, r.acc_low};
    if (!lng) e = {32'h0000_0000, a * b + (ac ? r.accumulate : 32'h0000_0000)};
    if (uns) m = ~|b[31:8] ? 1 : ~|b[31:16] ? 2 : ~|b[31:24] ? 3 : 4;
    else m = (~|b[31:8] || &b[31:8]) ? 1 : (~|b[31:16] || &b[31:16]) ? 2 : (~|b[31:24] || &b[31:24]) ? 3 : 4;
    u_imu_core_model.issue(r, pest, lat, c);
    chk(lat === 1 + m + ac + lng, "cycle count");
    chk(c.write_low === 1'b1 && c.write_high === lng, "write strobes");
    chk(c.low === e[31:0], "low result");
    if (lng) chk(c.high === e[63:32], "high result");
    chk(c.write_flags === sf, "flag write");
    if (sf) chk(c.flags[3:2] === (lng ? {e[63], e == 0} : {e[31], e[31:0] == 0}), "sign and zero flags");
    if (sf) chk(c.flag_mask === (lng ? 4'hF : 4'hE), "flag mask");
    last = c;
  endtask

  // Short forms over every multiplier tier, accumulating ones pestered while busy.
  task automatic t_short();
    for (int i = 0; i < 5; i++) begin
      do_op(0, 1'(i % 2), 32'hFFFF_FFF6, mult_tab[i], 1'b0);
      do_op(1, 1'b1, 32'h0000_0014, mult_tab[i], 1'b1);
    end
  endtask

  // All four long forms over every multiplier tier.
  task automatic t_long();
    for (int k = 2; k < 6; k++) begin
      for (int i = 0; i < 5; i++) begin
        do_op(k, 1'b1, 32'h8765_4321, mult_tab[i], 1'(k % 2));
      end
    end
  endtask

  // Zero results, the largest unsigned accumulate and a long form without flag update.
  task automatic t_flags();
    do_op(0, 1'b1, 32'h0000_0000, mult_tab[4], 1'b0);
    do_op(4, 1'b1, 32'h0000_0000, mult_tab[0], 1'b0);
    do_op(3, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0);
    do_op(2, 1'b0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 1'b0);
  endtask

  // A failed condition gives no answer and leaves the results alone.
  task automatic t_cond();
    imu_pkg::imu_req_s r;
    imu_pkg::imu_rsp_s c;
    int lat;
    r = '0;
    r.set_flags = 1'b1;
    r.first_operand = 32'h0000_0007;
    r.multiplier = 32'h0000_0003;
    u_imu_core_model.issue(r, 1'b0, lat, c);
    chk(lat === 12 && busy === 1'b0, "no answer");
    chk(c.low === last.low && c.high === last.high && c.flags === last.flags, "results kept");
    chk(c.write_low === 1'b0 && c.write_flags === 1'b0, "no writes");
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    rst_n_in = 1'b0;
    repeat (16) @(negedge clk_in);
    chk(busy === 1'b0 && done === 1'b0 && rsp === '0, "reset state");
    rst_n_in = 1'b1;
    t_short();
    t_long();
    t_flags();
    t_cond();
    final_report();
  end
endmodule // imu_multiply_unit_tb
`default_nettype wire
